// ===== rpv_top.sv
/*
 Prescale timers, interrupt vector and BCD converters of the clock block.
 Assumes a 32 kHz enable pulse and outside calendar flags.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Alarm day: enable, zero, tens, units
// - Timer zero divides by two to code+1
// - Calendar mode fixes /256 and /128
// - Timer zero hold resets set; calendar overrides
// - Timer zero interval tap sets flag
// - Enable and flag; interrupt needs enable
// - Timer one source: crystal or timer zero
// - Timer one divide uses same ratios
// - Timer one hold resets set; calendar overrides
// - Timer one interval tap sets flag
// - Timer one event wakes deepest sleep
// - Counters are eight bits read/write
// - Vector codes zero through 0Ch
// - Ready highest, priority falls with code
// - Binary write reads back as BCD
// - BCD write reads back as binary
// - Reserved control bits read zero
module rpv_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic xtal_tick,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic ready_flag,
	input wire logic interval_event_flag,
	input wire logic alarm_flag,
	input wire logic osc_fault_flag,
	output logic [4:0] src_clear,
	output logic pre0_irq,
	output logic pre1_irq,
	output logic wake_request,
	output logic alarm_enable,
	output logic [5:0] alarm_day_value
);
	// Control register fields
	logic [2:0] pre0_divide_sel_r;
	logic pre0_hold_r;
	logic [2:0] pre0_interval_sel_r;
	logic pre0_irq_enable_r;
	logic [1:0] pre1_source_sel_r;
	logic [2:0] pre1_divide_sel_r;
	logic pre1_hold_r;
	logic [2:0] pre1_interval_sel_r;
	logic pre1_irq_enable_r;
	// Mode register bits
	logic calendar_mode_r;
	logic calendar_hold_r;
	// Alarm day fields
	logic alarm_enable_r;
	logic [1:0] alarm_tens_r;
	logic [3:0] alarm_units_r;
	// Converter stores
	logic [15:0] bin_to_dec_value_r;
	logic [15:0] dec_to_bin_value_r;
	// Timer outputs
	logic [7:0] pre0_counter;
	logic [7:0] pre1_counter;
	logic pre0_tick;
	logic pre1_tick;
	logic pre0_event_flag;
	logic pre1_event_flag;
	// Effective configuration
	logic [2:0] div0_eff;
	logic [2:0] div1_eff;
	logic hold0_eff;
	logic hold1_eff;
	logic src1_tick;
	// Vector state
	rpv_pkg::rpv_src_type top_src;
	logic [15:0] vector_value;
	logic vec_rd;
	logic [5:0] pend;
	// Decoded write strobes
	logic wr_ctl0;
	logic wr_ctl1;

	// Binary to four BCD digits, double dabble
	function automatic logic [15:0] bin_to_bcd(input logic [11:0] b);
		logic [27:0] s;
		s = {16'h0000, b};
		for (int i = 0; i < 12; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (s[12+4*d +: 4] > 4'h4) begin
					s[12+4*d +: 4] = s[12+4*d +: 4] + 4'h3;
				end
			end
			s = s << 1;
		end
		bin_to_bcd = s[27:12];
	endfunction : bin_to_bcd

	// Four BCD digits to 12-bit binary
	function automatic logic [11:0] bcd_to_bin(input logic [15:0] v);
		logic [15:0] acc;
		acc = 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064 + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
		bcd_to_bin = acc[11:0];
	endfunction : bcd_to_bin

	assign wr_ctl0 = reg_wr & (reg_addr == rpv_pkg::IDX_PRE0_CTL);
	assign wr_ctl1 = reg_wr & (reg_addr == rpv_pkg::IDX_PRE1_CTL);
	assign vec_rd = reg_rd & (reg_addr == rpv_pkg::IDX_VECTOR);

	assign div0_eff = calendar_mode_r ? rpv_pkg::CAL_DIV0_CODE : pre0_divide_sel_r;
	assign div1_eff = calendar_mode_r ? rpv_pkg::CAL_DIV1_CODE : pre1_divide_sel_r;
	assign hold0_eff = calendar_mode_r ? calendar_hold_r : pre0_hold_r;
	assign hold1_eff = calendar_mode_r ? calendar_hold_r : pre1_hold_r;
	assign src1_tick = (calendar_mode_r | pre1_source_sel_r[1]) ? pre0_tick : xtal_tick;

	// Control fields of timer zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre0_divide_sel_r <= '0;
			pre0_hold_r <= rpv_pkg::HOLD_RESET;
			pre0_interval_sel_r <= '0;
			pre0_irq_enable_r <= 1'b0;
		end else if (wr_ctl0) begin
			pre0_divide_sel_r <= reg_wdata[rpv_pkg::DIV_HI:rpv_pkg::DIV_LO];
			pre0_hold_r <= reg_wdata[rpv_pkg::HOLD_BIT];
			pre0_interval_sel_r <= reg_wdata[rpv_pkg::IVL_HI:rpv_pkg::IVL_LO];
			pre0_irq_enable_r <= reg_wdata[rpv_pkg::IE_BIT];
		end
	end

	// Control fields of timer one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre1_source_sel_r <= '0;
			pre1_divide_sel_r <= '0;
			pre1_hold_r <= rpv_pkg::HOLD_RESET;
			pre1_interval_sel_r <= '0;
			pre1_irq_enable_r <= 1'b0;
		end else if (wr_ctl1) begin
			pre1_source_sel_r <= reg_wdata[rpv_pkg::SRC_HI:rpv_pkg::SRC_LO];
			pre1_divide_sel_r <= reg_wdata[rpv_pkg::DIV_HI:rpv_pkg::DIV_LO];
			pre1_hold_r <= reg_wdata[rpv_pkg::HOLD_BIT];
			pre1_interval_sel_r <= reg_wdata[rpv_pkg::IVL_HI:rpv_pkg::IVL_LO];
			pre1_irq_enable_r <= reg_wdata[rpv_pkg::IE_BIT];
		end
	end

	// Mode bits from the calendar side
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			calendar_mode_r <= 1'b0;
			calendar_hold_r <= 1'b0;
		end else if (reg_wr && reg_addr == rpv_pkg::IDX_MODE) begin
			calendar_mode_r <= reg_wdata[rpv_pkg::MODE_CAL_BIT];
			calendar_hold_r <= reg_wdata[rpv_pkg::MODE_HOLD_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alarm_enable_r <= 1'b0;
			alarm_tens_r <= '0;
			alarm_units_r <= '0;
		end else if (reg_wr && reg_addr == rpv_pkg::IDX_ALARM_DAY) begin
			alarm_enable_r <= reg_wdata[rpv_pkg::ADAY_EN_BIT];
			alarm_tens_r <= reg_wdata[rpv_pkg::ADAY_TENS_HI:rpv_pkg::ADAY_TENS_LO];
			alarm_units_r <= reg_wdata[rpv_pkg::ADAY_UNITS_HI:rpv_pkg::ADAY_UNITS_LO];
		end
	end
	assign alarm_enable = alarm_enable_r;
	assign alarm_day_value = {alarm_tens_r, alarm_units_r};

	// binary in, BCD kept for reads
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bin_to_dec_value_r <= rpv_pkg::WORD_ZERO;
		end else if (reg_wr && reg_addr == rpv_pkg::IDX_BIN2DEC) begin
			bin_to_dec_value_r <= bin_to_bcd(reg_wdata[11:0]);
		end
	end

	// BCD in, binary kept for reads
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dec_to_bin_value_r <= rpv_pkg::WORD_ZERO;
		end else if (reg_wr && reg_addr == rpv_pkg::IDX_DEC2BIN) begin
			dec_to_bin_value_r <= {4'h0, bcd_to_bin(reg_wdata)};
		end
	end

	// Timer zero
	rpv_prescaler #(.WIDTH(8)) u_pre0 (
		.core_clk(core_clk),
		.rst(rst),
		.tick_in(xtal_tick),
		.hold(hold0_eff),
		.div_code(div0_eff),
		.ivl_code(pre0_interval_sel_r),
		.cnt_wr(reg_wr && reg_addr == rpv_pkg::IDX_PRE0_CNT),
		.cnt_wdata(reg_wdata[7:0]),
		.flag_wr(wr_ctl0),
		.flag_wdata(reg_wdata[rpv_pkg::FLAG_BIT]),
		.flag_clr(vec_rd && top_src == rpv_pkg::RPV_SRC_PRE0),
		.count(pre0_counter),
		.tick_out(pre0_tick),
		.flag(pre0_event_flag)
	);

	// Timer one
	// interval tap of timer one
	rpv_prescaler #(.WIDTH(8)) u_pre1 (
		.core_clk(core_clk),
		.rst(rst),
		.tick_in(src1_tick),
		.hold(hold1_eff),
		.div_code(div1_eff),
		.ivl_code(pre1_interval_sel_r),
		.cnt_wr(reg_wr && reg_addr == rpv_pkg::IDX_PRE1_CNT),
		.cnt_wdata(reg_wdata[7:0]),
		.flag_wr(wr_ctl1),
		.flag_wdata(reg_wdata[rpv_pkg::FLAG_BIT]),
		.flag_clr(vec_rd && top_src == rpv_pkg::RPV_SRC_PRE1),
		.count(pre1_counter),
		.tick_out(pre1_tick),
		.flag(pre1_event_flag)
	);

	assign pre0_irq = pre0_event_flag & pre0_irq_enable_r;
	assign pre1_irq = pre1_event_flag & pre1_irq_enable_r;
	// timer one event wakes deep sleep
	assign wake_request = pre1_irq;

	// Pending sources in priority order
	assign pend = {osc_fault_flag, pre1_irq, pre0_irq, alarm_flag, interval_event_flag, ready_flag};

	always_comb begin
		top_src = rpv_pkg::RPV_SRC_NONE;
		for (int i = 5; i >= 0; i--) begin
			if (pend[i]) begin
				top_src = rpv_pkg::rpv_src_type'(3'(i));
			end
		end
	end

	always_comb begin
		unique case (top_src)
			rpv_pkg::RPV_SRC_READY: vector_value = rpv_pkg::VEC_READY;
			rpv_pkg::RPV_SRC_INTERVAL: vector_value = rpv_pkg::VEC_INTERVAL;
			rpv_pkg::RPV_SRC_ALARM: vector_value = rpv_pkg::VEC_ALARM;
			rpv_pkg::RPV_SRC_PRE0: vector_value = rpv_pkg::VEC_PRE0;
			rpv_pkg::RPV_SRC_PRE1: vector_value = rpv_pkg::VEC_PRE1;
			rpv_pkg::RPV_SRC_OSC: vector_value = rpv_pkg::VEC_OSC;
			default: vector_value = rpv_pkg::VEC_NONE;
		endcase
	end

	always_comb begin
		src_clear = '0;
		if (vec_rd) begin
			unique case (top_src)
				rpv_pkg::RPV_SRC_READY: src_clear[0] = 1'b1;
				rpv_pkg::RPV_SRC_INTERVAL: src_clear[1] = 1'b1;
				rpv_pkg::RPV_SRC_ALARM: src_clear[2] = 1'b1;
				rpv_pkg::RPV_SRC_OSC: src_clear[4] = 1'b1;
				default: src_clear[3] = 1'b0;
			endcase
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= rpv_pkg::WORD_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				rpv_pkg::IDX_ALARM_DAY: reg_rdata <= {8'h00, alarm_enable_r, 1'b0, alarm_tens_r, alarm_units_r};
				rpv_pkg::IDX_PRE0_CTL: reg_rdata <= {2'b00, pre0_divide_sel_r, 2'b00, pre0_hold_r, 3'b000,
					pre0_interval_sel_r, pre0_irq_enable_r, pre0_event_flag};
				rpv_pkg::IDX_PRE1_CTL: reg_rdata <= {pre1_source_sel_r, pre1_divide_sel_r, 2'b00, pre1_hold_r,
					3'b000, pre1_interval_sel_r, pre1_irq_enable_r, pre1_event_flag};
				rpv_pkg::IDX_PRE0_CNT: reg_rdata <= {8'h00, pre0_counter};
				rpv_pkg::IDX_PRE1_CNT: reg_rdata <= {8'h00, pre1_counter};
				rpv_pkg::IDX_VECTOR: reg_rdata <= vector_value;
				rpv_pkg::IDX_BIN2DEC: reg_rdata <= bin_to_dec_value_r;
				rpv_pkg::IDX_DEC2BIN: reg_rdata <= dec_to_bin_value_r;
				rpv_pkg::IDX_MODE: reg_rdata <= {14'h0000, calendar_hold_r, calendar_mode_r};
				default: reg_rdata <= rpv_pkg::WORD_ZERO;
			endcase
		end else begin
			reg_rdata <= rpv_pkg::WORD_ZERO;
		end
	end

	// Vector read returns the code seen at the strobe
	vector_read_a: assert property (@(posedge core_clk) disable iff (rst)
		vec_rd |=> reg_rdata == $past(vector_value))
		else $error("vector read data wrong");
	// Ready outranks everything
	ready_first_a: assert property (@(posedge core_clk) disable iff (rst)
		ready_flag |-> vector_value == rpv_pkg::VEC_READY)
		else $error("ready not highest priority");
	// Timer flag cleared by its vector read
	pre0_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		vec_rd && top_src == rpv_pkg::RPV_SRC_PRE0 && !u_pre0.ivl_hit |=> !pre0_event_flag)
		else $error("vector read left timer flag set");
	// Interrupt only with enable: clearing the enable drops the request
	irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_ctl1 && !reg_wdata[rpv_pkg::IE_BIT] |=> !pre1_irq && !wake_request)
		else $error("timer interrupt without enable");
	// Calendar fixes the ratios: timer zero wraps out at /256
	cal_div_a: assert property (@(posedge core_clk) disable iff (rst)
		calendar_mode_r && !calendar_hold_r && xtal_tick && &pre0_counter |=> pre0_tick)
		else $error("calendar divide not fixed");
	// Held counter stays put
	hold_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		hold0_eff && !(reg_wr && reg_addr == rpv_pkg::IDX_PRE0_CNT) |=> $stable(pre0_counter))
		else $error("held counter moved");
	// Binary write stored as its BCD conversion
	conv_read_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == rpv_pkg::IDX_BIN2DEC |=> bin_to_dec_value_r == bin_to_bcd($past(reg_wdata[11:0])))
		else $error("binary to BCD wrong");
	// Flag stays set without a clear
	flag_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
		pre1_event_flag && !wr_ctl1 && !vec_rd |=> pre1_event_flag)
		else $error("timer flag dropped");
endmodule : rpv_top

// ===== rpv_pkg.sv
/*
 Package for the clock prescaler, vector and converter block: register
 indices, field positions, reset values, vector codes.
 Assumes a plain word port with read data one cycle after the read strobe.
*/
package rpv_pkg;
	// Register indices (byte address is four times the index)
	localparam logic [3:0] IDX_ALARM_DAY = 4'h0;
	localparam logic [3:0] IDX_PRE0_CTL = 4'h1;
	localparam logic [3:0] IDX_PRE1_CTL = 4'h2;
	localparam logic [3:0] IDX_PRE0_CNT = 4'h3;
	localparam logic [3:0] IDX_PRE1_CNT = 4'h4;
	localparam logic [3:0] IDX_VECTOR = 4'h5;
	localparam logic [3:0] IDX_BIN2DEC = 4'h6;
	localparam logic [3:0] IDX_DEC2BIN = 4'h7;
	localparam logic [3:0] IDX_MODE = 4'h8;
	// Field positions in the control words
	localparam int SRC_HI = 15;
	localparam int SRC_LO = 14;
	localparam int DIV_HI = 13;
	localparam int DIV_LO = 11;
	localparam int HOLD_BIT = 8;
	localparam int IVL_HI = 4;
	localparam int IVL_LO = 2;
	localparam int IE_BIT = 1;
	localparam int FLAG_BIT = 0;
	// Alarm day-of-month field positions
	localparam int ADAY_EN_BIT = 7;
	localparam int ADAY_TENS_HI = 5;
	localparam int ADAY_TENS_LO = 4;
	localparam int ADAY_UNITS_HI = 3;
	localparam int ADAY_UNITS_LO = 0;
	// Mode register bit positions (calendar, calendar hold)
	localparam int MODE_CAL_BIT = 0;
	localparam int MODE_HOLD_BIT = 1;
	// Fixed calendar divide codes: /256 and /128
	localparam logic [2:0] CAL_DIV0_CODE = 3'h7;
	localparam logic [2:0] CAL_DIV1_CODE = 3'h6;
	// Reset values
	localparam logic HOLD_RESET = 1'b1;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	// Vector codes
	localparam logic [15:0] VEC_NONE = 16'h0000;
	localparam logic [15:0] VEC_READY = 16'h0002;
	localparam logic [15:0] VEC_INTERVAL = 16'h0004;
	localparam logic [15:0] VEC_ALARM = 16'h0006;
	localparam logic [15:0] VEC_PRE0 = 16'h0008;
	localparam logic [15:0] VEC_PRE1 = 16'h000A;
	localparam logic [15:0] VEC_OSC = 16'h000C;
	// Vector source order, highest priority first
	typedef enum logic [2:0] {
		RPV_SRC_READY,
		RPV_SRC_INTERVAL,
		RPV_SRC_ALARM,
		RPV_SRC_PRE0,
		RPV_SRC_PRE1,
		RPV_SRC_OSC,
		RPV_SRC_NONE
	} rpv_src_type;
endpackage : rpv_pkg

// ===== rpv_prescaler.sv
/*
 One 8-bit prescale counter with divide tap, interval tap and sticky flag.
 Assumes a one-cycle tick input and writes from the register port.
*/
`timescale 1ns/1ps
module rpv_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tick_in,
	input wire logic hold,
	input wire logic [2:0] div_code,
	input wire logic [2:0] ivl_code,
	input wire logic cnt_wr,
	input wire logic [WIDTH-1:0] cnt_wdata,
	input wire logic flag_wr,
	input wire logic flag_wdata,
	input wire logic flag_clr,
	output logic [WIDTH-1:0] count,
	output logic tick_out,
	output logic flag
);
	// Next count value, advance strobe and interval hit
	logic [WIDTH-1:0] count_nxt;
	logic adv;
	logic ivl_hit;

	// Bit k toggling low on a step marks a /2^(k+1) period
	function automatic logic tap_hit(input logic [WIDTH-1:0] old, input logic [2:0] code);
		logic [WIDTH-1:0] upd;
		upd = old + 1'b1;
		tap_hit = old[code] & ~upd[code];
	endfunction : tap_hit

	assign adv = tick_in & ~hold;
	assign count_nxt = count + 1'b1;
	assign ivl_hit = adv & tap_hit(count, ivl_code);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (cnt_wr) begin
			count <= cnt_wdata;
		end else if (adv) begin
			count <= count_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= adv & tap_hit(count, div_code);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (ivl_hit) begin
			flag <= 1'b1;
		end else if (flag_wr) begin
			flag <= flag_wdata;
		end else if (flag_clr) begin
			flag <= 1'b0;
		end
	end
endmodule : rpv_prescaler

// ===== rpv_top_bench.sv
/*
 Self-checking bench for the prescaler, vector and converter block.
 Assumes the package and top module of the design; the bench plays the calendar logic.
*/
`timescale 1ns/1ps
module rpv_top_bench;
	// One row: register index, word written, word read back
	typedef struct {
		logic [3:0] a;
		logic [15:0] w;
		logic [15:0] e;
	} rpv_row_type;
	logic core_clk, rst, xtal_tick, reg_wr, reg_rd; // Clock, reset, strobes
	logic ready_flag, interval_event_flag, alarm_flag, osc_fault_flag; // Calendar flags
	logic [3:0] reg_addr; // Register index
	logic [15:0] reg_wdata, reg_rdata, rd_val; // Bus data and last read
	logic [4:0] src_clear, clr_seen; // Clear pulses and their capture
	logic pre0_irq, pre1_irq, wake_request, alarm_enable; // Block outputs
	logic [5:0] alarm_day_value; // Alarm day digits
	logic [3:0] ca, na; // Control and count index per timer
	int mismatches, n_compared, t, k;
	// Ordinary write/read-back cases
	rpv_row_type rows[12] = '{
		'{rpv_pkg::IDX_ALARM_DAY, 16'hFFFF, 16'h00BF},
		'{rpv_pkg::IDX_PRE0_CTL, 16'hFFFE, 16'h391E},
		'{rpv_pkg::IDX_PRE1_CTL, 16'hFFFE, 16'hF91E},
		'{rpv_pkg::IDX_PRE0_CNT, 16'h12A5, 16'h00A5},
		'{rpv_pkg::IDX_PRE1_CNT, 16'h005A, 16'h005A},
		'{rpv_pkg::IDX_BIN2DEC, 16'h0FFF, 16'h4095},
		'{rpv_pkg::IDX_BIN2DEC, 16'h03E7, 16'h0999},
		'{rpv_pkg::IDX_DEC2BIN, 16'h4095, 16'h0FFF},
		'{rpv_pkg::IDX_DEC2BIN, 16'h0100, 16'h0064},
		'{rpv_pkg::IDX_VECTOR, 16'hFFFF, 16'h0000},
		'{4'hF, 16'hFFFF, 16'h0000},
		'{rpv_pkg::IDX_DEC2BIN, 16'h0000, 16'h0000}
	};
	// Expected clear pulses for the six vector reads
	logic [4:0] clr_exp[6] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h10};

	rpv_top i_rpv_top (.core_clk(core_clk), .rst(rst), .xtal_tick(xtal_tick), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ready_flag(ready_flag), .interval_event_flag(interval_event_flag), .alarm_flag(alarm_flag),
		.osc_fault_flag(osc_fault_flag), .src_clear(src_clear), .pre0_irq(pre0_irq), .pre1_irq(pre1_irq),
		.wake_request(wake_request), .alarm_enable(alarm_enable), .alarm_day_value(alarm_day_value));

	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;

	// Calendar side drops a flag when told to clear it
	always @(posedge core_clk) begin
		if (src_clear[0]) ready_flag <= 1'b0;
		if (src_clear[1]) interval_event_flag <= 1'b0;
		if (src_clear[2]) alarm_flag <= 1'b0;
		if (src_clear[4]) osc_fault_flag <= 1'b0;
	end

	// Compare and count
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One-cycle write strobe
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data taken in the following cycle
	task rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		#1 clr_seen = src_clear;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd

	task rdchk(input logic [3:0] a, input logic [15:0] exp);
		rd(a);
		check(rd_val, exp);
	endtask : rdchk

	// Crystal edges, each a one-cycle pulse, then let flags settle
	task ticks(input int n);
		repeat (n) begin
			@(posedge core_clk);
			xtal_tick <= 1'b1;
			@(posedge core_clk);
			xtal_tick <= 1'b0;
		end
		repeat (3) @(posedge core_clk);
	endtask : ticks

	// Verdict and end of run
	task end_sim;
		$display("counts: compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	// Watchdog, well beyond the expected few thousand cycles
	initial begin
		#400000;
		mismatches++;
		end_sim();
	end

	// Main sequence
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		{xtal_tick, reg_wr, reg_rd, ready_flag, interval_event_flag, alarm_flag, osc_fault_flag} = '0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		mismatches = 0;
		n_compared = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdchk(rows[i].a, rows[i].e);
		end
		check({15'h0000, alarm_enable}, 16'h0001);
		check({10'h000, alarm_day_value}, 16'h003F);
		$display("test table done");
		// interval taps of both timers, every code
		for (t = 0; t < 2; t++) begin
			ca = t ? rpv_pkg::IDX_PRE1_CTL : rpv_pkg::IDX_PRE0_CTL;
			na = t ? rpv_pkg::IDX_PRE1_CNT : rpv_pkg::IDX_PRE0_CNT;
			for (k = 0; k < 8; k++) begin
				wr(ca, 16'h0102 | (16'(k) << 2));
				wr(na, 16'h0000);
				wr(ca, 16'h0002 | (16'(k) << 2));
				ticks((2 << k) - 1);
				check({15'h0000, t ? pre1_irq : pre0_irq}, 16'h0000);
				ticks(1);
				check({15'h0000, t ? pre1_irq : pre0_irq}, 16'h0001);
			end
		end
		check({15'h0000, wake_request}, 16'h0001);
		$display("test interval done");
		// timer zero output clocks timer one
		for (k = 0; k < 8; k++) begin
			wr(rpv_pkg::IDX_PRE0_CTL, 16'h0100 | (16'(k) << 11));
			wr(rpv_pkg::IDX_PRE0_CNT, 16'h0000);
			wr(rpv_pkg::IDX_PRE1_CTL, 16'h8102);
			wr(rpv_pkg::IDX_PRE1_CNT, 16'h0000);
			wr(rpv_pkg::IDX_PRE0_CTL, 16'(k) << 11);
			wr(rpv_pkg::IDX_PRE1_CTL, 16'h8002);
			ticks((4 << k) - 1);
			check({15'h0000, pre1_irq}, 16'h0000);
			ticks(1);
			check({15'h0000, pre1_irq}, 16'h0001);
		end
		$display("test divide done");
		// calendar mode forces /256 into timer one, holds ignored
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h0100);
		wr(rpv_pkg::IDX_PRE0_CNT, 16'h0000);
		wr(rpv_pkg::IDX_PRE1_CTL, 16'h0102);
		wr(rpv_pkg::IDX_PRE1_CNT, 16'h0000);
		wr(rpv_pkg::IDX_MODE, 16'h0001);
		ticks(511);
		check({15'h0000, pre1_irq}, 16'h0000);
		ticks(1);
		check({15'h0000, pre1_irq}, 16'h0001);
		wr(rpv_pkg::IDX_MODE, 16'h0003);
		wr(rpv_pkg::IDX_PRE0_CNT, 16'h0033);
		ticks(5);
		rdchk(rpv_pkg::IDX_PRE0_CNT, 16'h0033);
		// hold bit stops the counter outside calendar mode
		wr(rpv_pkg::IDX_MODE, 16'h0000);
		wr(rpv_pkg::IDX_PRE0_CNT, 16'h0005);
		ticks(3);
		rdchk(rpv_pkg::IDX_PRE0_CNT, 16'h0005);
		$display("test calendar done");
		// flag without enable: no request, flag sticks
		wr(rpv_pkg::IDX_PRE1_CTL, 16'h0100);
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h0101);
		check({15'h0000, pre0_irq}, 16'h0000);
		rdchk(rpv_pkg::IDX_VECTOR, 16'h0000);
		rdchk(rpv_pkg::IDX_PRE0_CTL, 16'h0101);
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h0100);
		rdchk(rpv_pkg::IDX_PRE0_CTL, 16'h0100);
		// all sources pending, read in priority order
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h0103);
		wr(rpv_pkg::IDX_PRE1_CTL, 16'h0103);
		@(posedge core_clk);
		{ready_flag, interval_event_flag, alarm_flag, osc_fault_flag} <= 4'hF;
		@(posedge core_clk);
		check({13'h0000, pre0_irq, pre1_irq, wake_request}, 16'h0007);
		for (k = 0; k < 6; k++) begin
			rdchk(rpv_pkg::IDX_VECTOR, 16'(2 * (k + 1)));
			check({11'h000, clr_seen}, {11'h000, clr_exp[k]});
		end
		rdchk(rpv_pkg::IDX_VECTOR, 16'h0000);
		rdchk(rpv_pkg::IDX_PRE1_CTL, 16'h0102);
		$display("test vector done");
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h3803);
		wr(rpv_pkg::IDX_BIN2DEC, 16'h0123);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		check({14'h0000, pre0_irq, pre1_irq}, 16'h0000);
		rdchk(rpv_pkg::IDX_PRE0_CTL, 16'h0100);
		rdchk(rpv_pkg::IDX_PRE1_CTL, 16'h0100);
		rdchk(rpv_pkg::IDX_VECTOR, 16'h0000);
		rdchk(rpv_pkg::IDX_BIN2DEC, 16'h0000);
		rdchk(rpv_pkg::IDX_DEC2BIN, 16'h0000);
		// software rewrites the configuration after the reset
		wr(rpv_pkg::IDX_PRE0_CTL, 16'h3803);
		rdchk(rpv_pkg::IDX_PRE0_CTL, 16'h3803);
		$display("test reset done");
		end_sim();
	end
endmodule : rpv_top_bench
